// File: logic/i2cst_regs.svh
// Register offsets, field positions, reset values and timing counts
// of the start trigger block. Assumes a 100 MHz clk.
`ifndef I2CST_REGS_SVH
`define I2CST_REGS_SVH

// Byte offsets on the AXI4-Lite bus
`define I2CST_CTRL_OFS 8'h00
`define I2CST_FLAG_OFS 8'h04
`define I2CST_STAT_OFS 8'h08
`define I2CST_IRQ_OFS  8'h0c
`define I2CST_MASK_OFS 8'h10

// Control register bits
`define I2CST_CTRL_STOP 0
`define I2CST_CTRL_STRT 1
`define I2CST_CTRL_WREL 5
`define I2CST_CTRL_EXIT 6
`define I2CST_CTRL_EN   7

// Flag register bits
`define I2CST_FLAG_RSVD 0
`define I2CST_FLAG_FAIL 7

// Interrupt status and mask bits
`define I2CST_IRQ_STRT 0
`define I2CST_IRQ_FAIL 1
`define I2CST_IRQ_STOP 2
`define I2CST_IRQ_ARB  3

// Reset values
`define I2CST_FLAG_RST 8'h00
`define I2CST_MASK_RST 4'h0

// Timing: rated hold and setup times, rounded up to cycles
`define I2CST_CLK_NS   10
`define I2CST_HOLD_NS  4000
`define I2CST_SETUP_NS 4000
`define I2CST_HOLD_CYC  ((`I2CST_HOLD_NS + `I2CST_CLK_NS - 1) / `I2CST_CLK_NS)
`define I2CST_SETUP_CYC ((`I2CST_SETUP_NS + `I2CST_CLK_NS - 1) / `I2CST_CLK_NS)

`endif

// File: logic/i2cst_pkg.sv
// Types shared by the start trigger block.
// Assumes the constants of i2cst_regs.svh.
package i2cst_pkg;

    // Bus sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_STA_HOLD,
        ST_WAIT,
        ST_RS_REL,
        ST_RS_SCL,
        ST_SP_SCL
    } i2cst_state_type;

endpackage

// File: logic/i2cst_line_sync.sv
// Synchroniser and start/stop detector for the two bus lines.
// Assumes the lines are asynchronous to clk.
`timescale 1ns/10ps
module i2cst_line_sync (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic clockLineIn,
    input  wire logic dataLineIn,
    output logic      clockLineSync,
    output logic      dataLineSync,
    output logic      startDet,
    output logic      stopDet
);
    logic [1:0] meta_ff;
    logic [1:0] sync_ff;
    logic [1:0] prev_ff;
    wire  [1:0] rawIn = {dataLineIn, clockLineIn};

    // Three stages per line; the second and third feed logic, the first does not
    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1)
        begin : g_line
            always_ff @(posedge clk)
            begin
                if (!rstn)
                begin
                    meta_ff[i] <= 1'b1;
                    sync_ff[i] <= 1'b1;
                    prev_ff[i] <= 1'b1;
                end
                else
                begin
                    meta_ff[i] <= rawIn[i];
                    sync_ff[i] <= meta_ff[i];
                    prev_ff[i] <= sync_ff[i];
                end
            end
        end
    endgenerate

    // Data edge while clock stays high marks a condition
    assign clockLineSync = sync_ff[0];
    assign dataLineSync  = sync_ff[1];
    assign startDet = sync_ff[0] & prev_ff[0] & prev_ff[1] & ~sync_ff[1];
    assign stopDet  = sync_ff[0] & prev_ff[0] & ~prev_ff[1] & sync_ff[1];
endmodule

// File: logic/i2cst_start_trigger.sv
// Start/restart trigger of an I2C bus controller with AXI4-Lite registers.
// Assumes open-drain lines resolved outside and a 100 MHz clk.
`timescale 1ns/10ps
`include "i2cst_regs.svh"
module i2cst_start_trigger #(
    parameter logic [15:0] HOLD_CYC  = 16'(`I2CST_HOLD_CYC),
    parameter logic [15:0] SETUP_CYC = 16'(`I2CST_SETUP_CYC)
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [7:0]  awaddr,
    input  wire logic        wvalid,
    output logic             wready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    output logic             bvalid,
    input  wire logic        bready,
    output logic [1:0]       bresp,
    input  wire logic        arvalid,
    output logic             arready,
    input  wire logic [7:0]  araddr,
    output logic             rvalid,
    input  wire logic        rready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    input  wire logic        clockLineIn,
    output logic             clockLineOut,
    output logic             clockLineOe,
    input  wire logic        dataLineIn,
    output logic             dataLineOut,
    output logic             dataLineOe,
    output logic             irq
);
    // Bus slave state
    logic        awHeld_ff, wHeld_ff, awready_ff, wready_ff;
    logic [7:0]  awAddr_ff;
    logic [7:0]  wData_ff;
    logic        wStrb0_ff;
    logic        bvalid_ff, arready_ff, rvalid_ff;
    logic [1:0]  bresp_ff, rresp_ff;
    logic [31:0] rdata_ff;

    // Control state
    logic        en_ff, startPend_ff, stopTrig_ff;
    logic        resDis_ff, fail_ff, busBusy_ff, master_ff;
    logic [3:0]  irqStat_ff, mask_ff;
    logic        irq_ff;
    logic        clockOe_ff, dataOe_ff;
    logic [15:0] cnt_ff;
    i2cst_pkg::i2cst_state_type state_ff;

    // Sequencer next values
    i2cst_pkg::i2cst_state_type nxt_state;
    logic [15:0] nxt_cnt;
    logic        nxt_clockOe, nxt_dataOe, nxt_master;
    logic        startGen, stopGen, arbLost;

    // Synchronised lines
    logic clockS, dataS, startDet, stopDet;

    i2cst_line_sync u_sync (
        .clk           (clk),
        .rstn          (rstn),
        .clockLineIn   (clockLineIn),
        .dataLineIn    (dataLineIn),
        .clockLineSync (clockS),
        .dataLineSync  (dataS),
        .startDet      (startDet),
        .stopDet       (stopDet)
    );

    // Write decode; a write happens once address and data are both held
    wire doWrite = awHeld_ff & wHeld_ff & ~bvalid_ff;
    wire wHitCtrl = (awAddr_ff == `I2CST_CTRL_OFS);
    wire wHitFlag = (awAddr_ff == `I2CST_FLAG_OFS);
    wire wHitStat = (awAddr_ff == `I2CST_STAT_OFS);
    wire wHitIrq  = (awAddr_ff == `I2CST_IRQ_OFS);
    wire wHitMask = (awAddr_ff == `I2CST_MASK_OFS);
    wire wMapped  = wHitCtrl | wHitFlag | wHitStat | wHitIrq | wHitMask;
    wire wLane    = doWrite & wStrb0_ff;
    wire ctrlWr   = wLane & wHitCtrl;
    wire flagWr   = wLane & wHitFlag;
    wire maskWr   = wLane & wHitMask;

    // Enable as seen by a write that also changes it
    wire enNow   = ctrlWr ? wData_ff[`I2CST_CTRL_EN] : en_ff;
    wire wrStart = ctrlWr & wData_ff[`I2CST_CTRL_STRT] & enNow;
    wire wrStop  = ctrlWr & wData_ff[`I2CST_CTRL_STOP] & enNow;
    wire exitReq = ctrlWr & wData_ff[`I2CST_CTRL_EXIT];
    wire waitRel = ctrlWr & wData_ff[`I2CST_CTRL_WREL];
    // Another master owns the bus and reservation is off
    wire rejectStart = wrStart & busBusy_ff & ~master_ff & resDis_ff;
    wire kill = ~enNow | exitReq;

    // Read decode
    wire rHitCtrl = (araddr == `I2CST_CTRL_OFS);
    wire rHitFlag = (araddr == `I2CST_FLAG_OFS);
    wire rHitStat = (araddr == `I2CST_STAT_OFS);
    wire rHitIrq  = (araddr == `I2CST_IRQ_OFS);
    wire rHitMask = (araddr == `I2CST_MASK_OFS);
    wire rMapped  = rHitCtrl | rHitFlag | rHitStat | rHitIrq | rHitMask;
    wire arTake   = arvalid & arready_ff;
    wire irqRdClr = arTake & rHitIrq;

    // Trigger bits always read zero; only the enable reads back
    wire [7:0] ctrlRd = {en_ff, 7'h00};
    wire [7:0] flagRd = {fail_ff, 6'h00, resDis_ff};
    wire waiting = (state_ff == i2cst_pkg::ST_WAIT);
    wire [7:0] statRd = {1'b0, stopTrig_ff, startPend_ff, dataS, clockS, waiting, master_ff, busBusy_ff};
    wire [7:0] rdByte = rHitCtrl ? ctrlRd :
                        rHitFlag ? flagRd :
                        rHitStat ? statRd :
                        rHitIrq  ? {4'h0, irqStat_ff} :
                        rHitMask ? {4'h0, mask_ff} : 8'h00;

    // Event vector for the sticky status
    wire [3:0] events = {arbLost, stopGen, rejectStart, startGen};
    wire [3:0] nxt_irqStat = (irqRdClr ? 4'h0 : irqStat_ff) | events;

    // Write channels, taken independently in either order
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            awHeld_ff  <= 1'b0;
            awready_ff <= 1'b1;
            awAddr_ff  <= 8'h00;
        end
        else if (awvalid && awready_ff)
        begin
            awHeld_ff  <= 1'b1;
            awready_ff <= 1'b0;
            awAddr_ff  <= awaddr;
        end
        else if (doWrite)
        begin
            awHeld_ff  <= 1'b0;
            awready_ff <= 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            wHeld_ff  <= 1'b0;
            wready_ff <= 1'b1;
            wData_ff  <= 8'h00;
            wStrb0_ff <= 1'b0;
        end
        else if (wvalid && wready_ff)
        begin
            wHeld_ff  <= 1'b1;
            wready_ff <= 1'b0;
            wData_ff  <= wdata[7:0];
            wStrb0_ff <= wstrb[0];
        end
        else if (doWrite)
        begin
            wHeld_ff  <= 1'b0;
            wready_ff <= 1'b1;
        end
    end

    // Write response; unmapped offsets answer with a slave error
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= 2'h0;
        end
        else if (doWrite)
        begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= wMapped ? 2'h0 : 2'h2;
        end
        else if (bready)
        begin
            bvalid_ff <= 1'b0;
        end
    end

    // Read channel, one read at a time
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            arready_ff <= 1'b1;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h0000_0000;
            rresp_ff   <= 2'h0;
        end
        else if (arTake)
        begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b1;
            rdata_ff   <= {24'h00_0000, rdByte};
            rresp_ff   <= rMapped ? 2'h0 : 2'h2;
        end
        else if (rvalid_ff && rready)
        begin
            arready_ff <= 1'b1;
            rvalid_ff  <= 1'b0;
        end
    end

    // Bus sequencer; sda is pulled only where the sequence calls for it
    always_comb
    begin
        nxt_state   = state_ff;
        nxt_cnt     = (cnt_ff != 16'h0000) ? cnt_ff - 16'h0001 : cnt_ff;
        nxt_clockOe = clockOe_ff;
        nxt_dataOe  = dataOe_ff;
        nxt_master  = master_ff;
        startGen    = 1'b0;
        stopGen     = 1'b0;
        arbLost     = 1'b0;
        case (state_ff)
            i2cst_pkg::ST_IDLE:
            begin
                nxt_clockOe = 1'b0;
                nxt_dataOe  = 1'b0;
                // Free bus with both lines high: data falls first
                if (startPend_ff && !busBusy_ff && clockS && dataS)
                begin
                    nxt_state  = i2cst_pkg::ST_STA_HOLD;
                    nxt_dataOe = 1'b1;
                    nxt_cnt    = HOLD_CYC;
                end
            end
            i2cst_pkg::ST_STA_HOLD:
            begin
                // Clock falls only after the hold time
                if (cnt_ff == 16'h0000)
                begin
                    nxt_state   = i2cst_pkg::ST_WAIT;
                    nxt_clockOe = 1'b1;
                    nxt_master  = 1'b1;
                    startGen    = 1'b1;
                end
            end
            i2cst_pkg::ST_WAIT:
            begin
                // Master wait: clock held low until software acts
                if (stopTrig_ff)
                begin
                    nxt_state   = i2cst_pkg::ST_SP_SCL;
                    nxt_dataOe  = 1'b1;
                    nxt_clockOe = 1'b0;
                    nxt_cnt     = SETUP_CYC;
                end
                else if (waitRel && startPend_ff)
                begin
                    nxt_state  = i2cst_pkg::ST_RS_REL;
                    nxt_dataOe = 1'b0;
                    nxt_cnt    = HOLD_CYC;
                end
            end
            i2cst_pkg::ST_RS_REL:
            begin
                // Data released while clock is still low
                if (cnt_ff == 16'h0000)
                begin
                    nxt_state   = i2cst_pkg::ST_RS_SCL;
                    nxt_clockOe = 1'b0;
                    nxt_cnt     = SETUP_CYC;
                end
            end
            i2cst_pkg::ST_RS_SCL:
            begin
                // A stretching slave holds the clock; restart the setup count
                if (!clockS)
                begin
                    nxt_cnt = SETUP_CYC;
                end
                else if (!dataS)
                begin
                    nxt_state  = i2cst_pkg::ST_IDLE;
                    nxt_master = 1'b0;
                    arbLost    = 1'b1;
                end
                else if (cnt_ff == 16'h0000)
                begin
                    nxt_state  = i2cst_pkg::ST_STA_HOLD;
                    nxt_dataOe = 1'b1;
                    nxt_cnt    = HOLD_CYC;
                end
            end
            i2cst_pkg::ST_SP_SCL:
            begin
                // Data low, clock released; data rises after setup
                if (!clockS)
                begin
                    nxt_cnt = SETUP_CYC;
                end
                else if (cnt_ff == 16'h0000)
                begin
                    nxt_state  = i2cst_pkg::ST_IDLE;
                    nxt_dataOe = 1'b0;
                    nxt_master = 1'b0;
                    stopGen    = 1'b1;
                end
            end
            default:
            begin
                nxt_state = i2cst_pkg::ST_IDLE;
            end
        endcase
        // Disable or exit lets go of both lines at once
        if (kill)
        begin
            nxt_state   = i2cst_pkg::ST_IDLE;
            nxt_clockOe = 1'b0;
            nxt_dataOe  = 1'b0;
            nxt_master  = 1'b0;
            startGen    = 1'b0;
            stopGen     = 1'b0;
            arbLost     = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            state_ff   <= i2cst_pkg::ST_IDLE;
            cnt_ff     <= 16'h0000;
            clockOe_ff <= 1'b0;
            dataOe_ff  <= 1'b0;
            master_ff  <= 1'b0;
        end
        else
        begin
            state_ff   <= nxt_state;
            cnt_ff     <= nxt_cnt;
            clockOe_ff <= nxt_clockOe;
            dataOe_ff  <= nxt_dataOe;
            master_ff  <= nxt_master;
        end
    end

    // Start trigger: hardware clears win, software cannot re-arm early
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            startPend_ff <= 1'b0;
        end
        else
        begin
            startPend_ff <= (startPend_ff | (wrStart & ~rejectStart))
                            & ~(kill | startGen | arbLost | rejectStart);
        end
    end

    // Stop trigger ends on a detected stop, a lost arbitration, a disable or an exit
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            stopTrig_ff <= 1'b0;
        end
        else
        begin
            stopTrig_ff <= (stopTrig_ff | wrStop) & ~(kill | stopDet | arbLost);
        end
    end

    // Flag register; a new failure beats a clearing write
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            resDis_ff <= 1'(`I2CST_FLAG_RST >> `I2CST_FLAG_RSVD);
            fail_ff   <= 1'b0;
        end
        else
        begin
            if (flagWr)
            begin
                resDis_ff <= wData_ff[`I2CST_FLAG_RSVD];
            end
            fail_ff <= ((flagWr ? wData_ff[`I2CST_FLAG_FAIL] : fail_ff) & fail_ff) | rejectStart;
        end
    end

    // Bus occupancy seen from the lines, ours included
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            busBusy_ff <= 1'b0;
        end
        else if (startDet)
        begin
            busBusy_ff <= 1'b1;
        end
        else if (stopDet)
        begin
            busBusy_ff <= 1'b0;
        end
    end

    // Enable, mask and sticky interrupt status
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            en_ff      <= 1'b0;
            mask_ff    <= `I2CST_MASK_RST;
            irqStat_ff <= 4'h0;
            irq_ff     <= 1'b0;
        end
        else
        begin
            en_ff      <= enNow;
            irqStat_ff <= nxt_irqStat;
            if (maskWr)
            begin
                mask_ff <= wData_ff[3:0];
            end
            irq_ff <= |(nxt_irqStat & (maskWr ? wData_ff[3:0] : mask_ff));
        end
    end

    // Ports; lines are open-drain, so the driven level is always low
    assign awready      = awready_ff;
    assign wready       = wready_ff;
    assign bvalid       = bvalid_ff;
    assign bresp        = bresp_ff;
    assign arready      = arready_ff;
    assign rvalid       = rvalid_ff;
    assign rdata        = rdata_ff;
    assign rresp        = rresp_ff;
    assign clockLineOut = 1'b0;
    assign dataLineOut  = 1'b0;
    assign clockLineOe  = clockOe_ff;
    assign dataLineOe   = dataOe_ff;
    assign irq          = irq_ff;
endmodule

// File: bench/i2cst_start_asserts.sv
// Port checker for the start trigger block.
// Assumes binding to i2cst_start_trigger; one clk domain, rstn low resets.
`timescale 1ns/10ps
module i2cst_start_asserts #(
    parameter logic [15:0] HOLD_CYC  = 16'h0004,
    parameter logic [15:0] SETUP_CYC = 16'h0004
) (
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic [7:0]  araddr,
    input wire logic        rvalid,
    input wire logic [31:0] rdata,
    input wire logic        clockLineIn,
    input wire logic        clockLineOut,
    input wire logic        clockLineOe,
    input wire logic        dataLineIn,
    input wire logic        dataLineOut,
    input wire logic        dataLineOe
);
    logic [15:0] holdCnt_ff;
    logic [15:0] highCnt_ff;
    logic [7:0]  rdAddr_ff;
    logic [15:0] nxt_holdCnt;
    logic [15:0] nxt_highCnt;
    logic [7:0]  nxt_rdAddr;

    // Cycles of data pulled with clock free, and of clock line high
    assign nxt_holdCnt = (dataLineOe && !clockLineOe) ? holdCnt_ff + 16'h0001 : 16'h0000;
    assign nxt_highCnt = (clockLineIn && !clockLineOe) ? highCnt_ff + 16'h0001 : 16'h0000;
    assign nxt_rdAddr  = (arvalid && arready) ? araddr : rdAddr_ff;

    // Counters never wrap within a run, so no saturation is kept
    always_ff @(posedge clk)
    begin
        holdCnt_ff <= rstn ? nxt_holdCnt : 16'h0000;
        highCnt_ff <= rstn ? nxt_highCnt : 16'h0000;
        rdAddr_ff  <= rstn ? nxt_rdAddr : 8'h00;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    chk_start_hold: assert property ($rose(clockLineOe) |-> dataLineOe && holdCnt_ff >= HOLD_CYC)
        else $error("clock pulled before hold time");
    chk_start_clock_high: assert property ($rose(dataLineOe) && !clockLineOe |-> clockLineIn)
        else $error("start formed with clock low");
    chk_start_free_line: assert property ($rose(dataLineOe) && !clockLineOe |-> $past(dataLineIn))
        else $error("start formed on busy data line");
    chk_stop_setup: assert property ($fell(dataLineOe) && !clockLineOe && !$fell(clockLineOe)
        |-> highCnt_ff >= SETUP_CYC)
        else $error("stop released data too early");
    chk_restart_release: assert property ($fell(dataLineOe) && clockLineOe |=> clockLineOe [*3])
        else $error("restart released clock too early");
    chk_open_drain: assert property (clockLineOut == 1'b0 && dataLineOut == 1'b0)
        else $error("line output not low");
    chk_ctrl_readback: assert property (rvalid && rdAddr_ff == 8'h00 |-> rdata[1:0] == 2'b00)
        else $error("trigger bits read back set");
    chk_flag_layout: assert property (rvalid && rdAddr_ff == 8'h04 |-> rdata[6:1] == 6'h00)
        else $error("flag register spare bits set");
endmodule

// File: bench/i2cst_bus_peer.sv
// Other master on the shared bus, pulling the open-drain lines.
// Assumes the bench resolves the lines with pull-ups.
`timescale 1ns/10ps
module i2cst_bus_peer (
    output logic clockPull,
    output logic dataPull
);
    // Both released; clock stands still outside frames
    initial
    begin
        clockPull = 1'b0;
        dataPull  = 1'b0;
    end

    // Start, nine clocks at 125 ns, then clock held low mid-transfer
    task frameStart();
        #3; // Keep clear of the clk sampling edge
        dataPull = 1'b1;
        #250;
        repeat (9)
        begin
            clockPull = 1'b1;
            #62.5;
            clockPull = 1'b0;
            #62.5;
        end
        clockPull = 1'b1;
    endtask

    // Stop: data held low, clock released, data released later
    task frameStop();
        dataPull = 1'b1;
        #62.5;
        clockPull = 1'b0;
        #500;
        dataPull = 1'b0;
    endtask
endmodule

// File: bench/tb_i2c_start_condition_trigger.sv
// Bench for the start trigger block over its AXI4-Lite registers.
// Assumes pulled-up lines shared with one peer master.
`timescale 1ns/10ps
module tb_i2c_start_condition_trigger;
    localparam logic [15:0] HOLD = 16'h0004;
    logic        clk, rstn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, irq, clockPull, dataPull;
    logic        clockLine, dataLine, clockLineOut, clockLineOe, dataLineOut, dataLineOe;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rdat;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rsp;
    int          errors, check_count;

    // Pull-ups: a line is low while any party pulls it
    assign clockLine = !(clockLineOe | clockPull);
    assign dataLine  = !(dataLineOe | dataPull);

    i2cst_start_trigger #(.HOLD_CYC(HOLD), .SETUP_CYC(HOLD)) dut_u (
        .clk(clk), .rstn(rstn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
        .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .clockLineIn(clockLine),
        .clockLineOut(clockLineOut), .clockLineOe(clockLineOe), .dataLineIn(dataLine),
        .dataLineOut(dataLineOut), .dataLineOe(dataLineOe), .irq(irq));

    i2cst_bus_peer peer_u (.clockPull(clockPull), .dataPull(dataPull));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task tally_and_finish();
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task cmp(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Ready is peeked at the falling edge, so release lands on the taking edge
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, done;
        @(posedge clk);
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        awaddr <= a;
        wdata <= d;
        bready <= 1'b1;
        done = 1'b0;
        while (!done)
        begin
            @(negedge clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            done = bvalid;
            rsp = bresp;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (done) bready <= 1'b0;
        end
    endtask

    // Offset 0x14 is unmapped: only the error response is judged
    task rd(input logic [7:0] a, input logic [31:0] e);
        logic ta, done;
        @(posedge clk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        done = 1'b0;
        while (!done)
        begin
            @(negedge clk);
            ta = arvalid && arready;
            done = rvalid;
            rdat = rdata;
            rsp = rresp;
            @(posedge clk);
            if (ta) arvalid <= 1'b0;
            if (done) rready <= 1'b0;
        end
        cmp(32'(rsp), (a == 8'h14) ? 32'h2 : 32'h0);
        if (a != 8'h14)
            cmp(rdat, e);
    endtask

    task waitIrq();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 3000)
        begin
            @(negedge clk);
            n++;
        end
        cmp(32'(irq), 32'h1);
    endtask

    initial
    begin
        {rstn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata, wstrb} = {16'h0000, 32'h0, 4'hf};
        errors = 0;
        check_count = 0;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        rd(8'h04, 32'h0);
        rd(8'h10, 32'h0);
        rd(8'h14, 32'h0);
        wr(8'h14, 32'hff);
        cmp(32'(rsp), 32'h2);
        // Free bus start, then idle in the wait state
        wr(8'h10, 32'hf);
        wr(8'h00, 32'h80);
        wr(8'h00, 32'h82);
        waitIrq();
        cmp(32'(dataLineOe), 32'h1);
        rd(8'h00, 32'h80);
        rd(8'h0c, 32'h1);
        repeat (50) @(posedge clk);
        cmp(32'(irq), 32'h0);
        cmp(32'(clockLineOe), 32'h1);
        // Restart from the wait, then stop; the trigger is set before the release
        wr(8'h00, 32'h82);
        wr(8'h00, 32'ha0);
        waitIrq();
        rd(8'h0c, 32'h1);
        wr(8'h00, 32'h81);
        waitIrq();
        rd(8'h0c, 32'h4);
        repeat (10) @(posedge clk);
        rd(8'h08, 32'h18);
        // Peer holds the bus: rejected set, failure event masked
        peer_u.frameStart();
        wr(8'h10, 32'hd);
        wr(8'h04, 32'h1);
        wr(8'h00, 32'h82);
        repeat (20) @(posedge clk);
        cmp(32'(irq), 32'h0);
        rd(8'h04, 32'h81);
        rd(8'h00, 32'h80);
        rd(8'h0c, 32'h2);
        cmp(32'(dataLineOe), 32'h0);
        // Reservation kept until the peer stops
        wr(8'h10, 32'hf);
        wr(8'h04, 32'h0);
        wr(8'h00, 32'h82);
        repeat (30) @(posedge clk);
        cmp(32'(dataLineOe), 32'h0);
        rd(8'h08, 32'h21);
        peer_u.frameStop();
        waitIrq();
        rd(8'h0c, 32'h1);
        // Exit drops the transfer; disabled block ignores a set
        wr(8'h00, 32'hc0);
        repeat (5) @(posedge clk);
        cmp(32'(dataLineOe), 32'h0);
        cmp(32'(clockLineOe), 32'h0);
        // No stop formed on exit, so the bus stays busy: a set stays pending until the next exit
        wr(8'h00, 32'h82);
        rd(8'h08, 32'h39);
        wr(8'h00, 32'hc0);
        rd(8'h08, 32'h19);
        wr(8'h00, 32'h0);
        wr(8'h00, 32'h2);
        repeat (20) @(posedge clk);
        cmp(32'(dataLineOe), 32'h0);
        rd(8'h00, 32'h0);
        tally_and_finish();
    end

    // Whole run is some five hundred cycles; this allows about a hundred times that
    initial
    begin
        #500000;
        errors++;
        tally_and_finish();
    end
endmodule

bind i2cst_start_trigger i2cst_start_asserts #(.HOLD_CYC(HOLD_CYC), .SETUP_CYC(SETUP_CYC)) chk_u (
    .clk(clk), .rstn(rstn), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
    .rdata(rdata), .clockLineIn(clockLineIn), .clockLineOut(clockLineOut), .clockLineOe(clockLineOe),
    .dataLineIn(dataLineIn), .dataLineOut(dataLineOut), .dataLineOe(dataLineOe));
